// ==== lst_core.sv ====
// Purpose: fetch and execute of load, store, transfer and word instructions
// Assumes: mem_rdata answers mem_addr combinationally in the same cycle
// Notes: each instruction holds the bus for exactly its listed cycle count
`timescale 1ns/1ps
module lst_core #(
	parameter int ADDR_BITS = lst_pkg::ADDR_W,
	parameter logic [15:0] START_PC = lst_pkg::RESET_PC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] mem_rdata,
	output logic [15:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	output logic instr_done,
	output logic illegal_op,
	output logic [7:0] acc,
	output logic [7:0] idx_x,
	output logic [7:0] idx_y,
	output logic [7:0] stack_ptr,
	output logic [7:0] psw,
	output logic [15:0] pc
);
	import lst_pkg::*;

	typedef enum logic {ST_FETCH, ST_EXEC} lst_state_t;

	generate
		if (ADDR_BITS != 16) begin : g_bad_addr
			$error("lst_core supports only a 16-bit address space");
		end
	endgenerate

	lst_state_t state_q;
	logic [2:0] cyc_q;
	logic [15:0] pc_q;
	logic [7:0] opcode_q;
	logic [7:0] op1_q;
	logic [7:0] op2_q;
	logic [7:0] dat_q;
	logic [7:0] hi_q;
	logic [15:0] wres_q;
	logic [7:0] acc_q;
	logic [7:0] x_q;
	logic [7:0] y_q;
	logic [7:0] sp_q;
	logic [7:0] psw_q;
	lst_mode_t mode;
	lst_op_t op;
	logic [1:0] nbytes;
	logic [2:0] ncyc;
	logic known;
	logic [2:0] rem;
	logic exec;
	logic opnd;
	logic done;
	logic g;
	logic is_store;
	logic is_word;
	logic inc_dec;
	logic word_act;
	logic indirect;
	logic mem_mode;
	logic [7:0] ptr_base;
	logic [15:0] alu_res;
	logic f_n;
	logic f_v;
	logic f_h;
	logic f_c;
	logic f_z;
	logic nz_upd;
	logic [7:0] nz_byte;

	function automatic logic [15:0] dp_addr(input logic gs,
		input logic [7:0] off);
		dp_addr = {7'h00, gs, off};
	endfunction

	function automatic logic [15:0] ea_of(input lst_mode_t m,
		input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] xv,
		input logic [7:0] yv, input logic gs, input logic [15:0] ptr);
		logic [7:0] sum_x;
		logic [7:0] sum_y;
		sum_x = b1 + xv;
		sum_y = b1 + yv;
		case (m)
			AM_DPX: ea_of = dp_addr(gs, sum_x);
			AM_DPY: ea_of = dp_addr(gs, sum_y);
			AM_ABS: ea_of = {b2, b1};
			AM_ABSY: ea_of = {b2, b1} + {8'h00, yv};
			AM_IDX: ea_of = ptr;
			AM_IDY: ea_of = ptr + {8'h00, yv};
			AM_XI, AM_XIP: ea_of = dp_addr(gs, xv);
			default: ea_of = dp_addr(gs, b1);
		endcase
	endfunction

	lst_decode u_decode (
		.opcode(opcode_q),
		.mode(mode),
		.op(op),
		.nbytes(nbytes),
		.ncyc(ncyc),
		.known(known)
	);

	lst_word_alu u_alu (
		.op(op),
		.a_word({y_q, acc_q}),
		.m_word({mem_rdata, dat_q}),
		.res(alu_res),
		.flag_n(f_n),
		.flag_v(f_v),
		.flag_h(f_h),
		.flag_c(f_c),
		.flag_z(f_z)
	);

	// rem counts down to the last cycle, where results commit
	assign exec = state_q == ST_EXEC;
	assign rem = ncyc - cyc_q - 3'h1;
	assign opnd = exec && (cyc_q < {1'b0, nbytes});
	assign done = exec && (rem == 3'h0);
	assign g = psw_q[PSW_G];
	assign is_store = op == OP_STORE_A || op == OP_STORE_X
		|| op == OP_STORE_Y;
	assign is_word = op == OP_W_ADD || op == OP_W_SUB || op == OP_W_CMP
		|| inc_dec || op == OP_W_LOAD || op == OP_W_STORE;
	assign inc_dec = op == OP_W_INC || op == OP_W_DEC;
	assign word_act = rem < (inc_dec ? 3'h4 : 3'h2);
	assign indirect = mode == AM_IDX || mode == AM_IDY;
	assign mem_mode = mode != AM_NONE && mode != AM_IMM;
	assign ptr_base = (mode == AM_IDX) ? op1_q + x_q : op1_q;

	// bus steering; the data access always ends on the final cycle
	always_comb begin
		mem_addr = pc_q;
		mem_rd = 1'b0;
		mem_wr = 1'b0;
		mem_wdata = 8'h00;
		if (!exec || opnd) begin
			mem_rd = 1'b1;
		end else if (is_word) begin
			if (word_act) begin
				mem_addr = dp_addr(g, rem[0] ? op1_q : op1_q + 8'h01);
				mem_wr = op == OP_W_STORE || (inc_dec && rem < 3'h2);
				mem_rd = !mem_wr;
				if (op == OP_W_STORE) begin
					mem_wdata = rem[0] ? acc_q : y_q;
				end else begin
					mem_wdata = rem[0] ? wres_q[7:0] : wres_q[15:8];
				end
			end
		end else if (op == OP_STORE_IMM) begin
			if (rem == 3'h0) begin
				mem_addr = dp_addr(g, op1_q);
				mem_wr = 1'b1;
				mem_wdata = op2_q;
			end
		end else if (indirect && rem != 3'h0) begin
			if (rem < 3'h3) begin
				mem_addr = dp_addr(g, ptr_base + {7'h00, rem == 3'h1});
				mem_rd = 1'b1;
			end
		end else if (mem_mode && (rem == 3'h0
			|| (op == OP_SWAP_MA && rem == 3'h1))) begin
			mem_addr = ea_of(mode, op1_q, op2_q, x_q, y_q, g, {hi_q, dat_q});
			mem_wr = is_store || op == OP_SWAP_MA && rem == 3'h0;
			mem_rd = !mem_wr;
			if (op == OP_STORE_X) begin
				mem_wdata = x_q;
			end else if (op == OP_STORE_Y) begin
				mem_wdata = y_q;
			end else begin
				mem_wdata = acc_q;
			end
		end
	end

	// instruction sequencing and operand capture
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_FETCH;
			cyc_q <= 3'h0;
			pc_q <= START_PC;
			opcode_q <= 8'h00;
			op1_q <= 8'h00;
			op2_q <= 8'h00;
		end else begin
			unique case (state_q)
				ST_FETCH: begin
					opcode_q <= mem_rdata;
					pc_q <= pc_q + 16'h0001;
					cyc_q <= 3'h1;
					state_q <= ST_EXEC;
				end
				ST_EXEC: begin
					if (opnd) begin
						pc_q <= pc_q + 16'h0001;
						if (cyc_q == 3'h1) begin
							op1_q <= mem_rdata;
						end else begin
							op2_q <= mem_rdata;
						end
					end
					if (done) begin
						cyc_q <= 3'h0;
						state_q <= ST_FETCH;
					end else begin
						cyc_q <= cyc_q + 3'h1;
					end
				end
			endcase
		end
	end

	// pointer bytes, exchanged byte and the low half of a word operand
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dat_q <= 8'h00;
			hi_q <= 8'h00;
			wres_q <= 16'h0000;
		end else if (exec && !opnd) begin
			if ((indirect && rem == 3'h2) || (is_word && word_act && rem[0])
				|| (op == OP_SWAP_MA && rem == 3'h1)) begin
				dat_q <= mem_rdata;
			end
			if (indirect && rem == 3'h1) begin
				hi_q <= mem_rdata;
			end
			// inc/dec result is held so both write cycles see one value
			if (inc_dec && rem == 3'h2) begin
				wres_q <= alu_res;
			end
		end
	end

	// architectural registers commit on the final cycle only
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= 8'h00;
			x_q <= 8'h00;
			y_q <= 8'h00;
			sp_q <= RESET_SP;
		end else if (done) begin
			case (op)
				OP_LOAD_A: acc_q <= mem_rdata;
				OP_LOAD_X: x_q <= mem_rdata;
				OP_LOAD_Y: y_q <= mem_rdata;
				OP_A_TO_X: x_q <= acc_q;
				OP_A_TO_Y: y_q <= acc_q;
				OP_SP_TO_X: x_q <= sp_q;
				OP_X_TO_A: acc_q <= x_q;
				OP_X_TO_SP: sp_q <= x_q;
				OP_Y_TO_A: acc_q <= y_q;
				OP_SWAP_AX: begin
					acc_q <= x_q;
					x_q <= acc_q;
				end
				OP_SWAP_AY: begin
					acc_q <= y_q;
					y_q <= acc_q;
				end
				OP_SWAP_XY: begin
					x_q <= y_q;
					y_q <= x_q;
				end
				OP_SWAP_MA: acc_q <= dat_q;
				OP_W_ADD, OP_W_SUB, OP_W_LOAD: begin
					acc_q <= alu_res[7:0];
					y_q <= alu_res[15:8];
				end
				default: begin
				end
			endcase
			if (mode == AM_XIP) begin
				x_q <= x_q + 8'h01;
			end
		end
	end

	// byte-wide N/Z source; stores and register swaps leave flags alone
	always_comb begin
		nz_upd = 1'b1;
		nz_byte = mem_rdata;
		case (op)
			OP_LOAD_A, OP_LOAD_X, OP_LOAD_Y: nz_byte = mem_rdata;
			OP_A_TO_X, OP_A_TO_Y: nz_byte = acc_q;
			OP_SP_TO_X: nz_byte = sp_q;
			OP_X_TO_A, OP_X_TO_SP: nz_byte = x_q;
			OP_Y_TO_A: nz_byte = y_q;
			OP_SWAP_MA: nz_byte = dat_q;
			default: nz_upd = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			psw_q <= RESET_PSW;
		end else if (done && known) begin
			if (nz_upd) begin
				psw_q[PSW_N] <= nz_byte[7];
				psw_q[PSW_Z] <= nz_byte == 8'h00;
			end
			if (inc_dec) begin
				psw_q[PSW_N] <= wres_q[15];
				psw_q[PSW_Z] <= wres_q == 16'h0000;
			end
			if (is_word && !inc_dec && op != OP_W_STORE) begin
				psw_q[PSW_N] <= f_n;
				psw_q[PSW_Z] <= f_z;
			end
			if (op == OP_W_ADD || op == OP_W_SUB || op == OP_W_CMP) begin
				psw_q[PSW_C] <= f_c;
			end
			if (op == OP_W_ADD || op == OP_W_SUB) begin
				psw_q[PSW_V] <= f_v;
				psw_q[PSW_H] <= f_h;
			end
		end
	end

	assign instr_done = done;
	assign illegal_op = done && !known;
	assign acc = acc_q;
	assign idx_x = x_q;
	assign idx_y = y_q;
	assign stack_ptr = sp_q;
	assign psw = psw_q;
	assign pc = pc_q;

	// checks below watch what this block drives and the mem_rdata it is given
	logic [15:0] ya_sum;
	assign ya_sum = {y_q, acc_q} + {mem_rdata, dat_q};

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	xinc_load_a: assert property (
		done && op == OP_LOAD_A && mode == AM_XIP
		|=> idx_x == $past(idx_x) + 8'h01 && acc == $past(mem_rdata))
		else $error("auto-increment load wrong");
	xinc_store_a: assert property (
		mem_wr && op == OP_STORE_A && mode == AM_XIP
		|-> mem_addr[7:0] == x_q && mem_wdata == acc_q && rem == 3'h0)
		else $error("auto-increment store wrong");
	imm_store_len_a: assert property (
		exec && cyc_q == 3'h1 && op == OP_STORE_IMM
		|-> !instr_done [*3] ##1 (instr_done && mem_wr))
		else $error("immediate store length wrong");
	store_flags_a: assert property (
		done && is_store |=> psw == $past(psw))
		else $error("store changed flags");
	xstore_data_a: assert property (
		mem_wr && op == OP_STORE_X |-> mem_wdata == idx_x)
		else $error("X store data wrong");
	copy_ax_a: assert property (
		done && op == OP_A_TO_X |=> idx_x == $past(acc)
		&& psw[PSW_Z] == ($past(acc) == 8'h00) && psw[PSW_N] == idx_x[7])
		else $error("A to X copy wrong");
	swap_xy_a: assert property (
		done && op == OP_SWAP_XY
		|=> idx_x == $past(idx_y) && idx_y == $past(idx_x))
		else $error("X/Y swap wrong");
	word_add_a: assert property (
		done && op == OP_W_ADD |=> {idx_y, acc} == $past(ya_sum))
		else $error("word add result wrong");
	word_cmp_a: assert property (
		done && op == OP_W_CMP
		|=> {idx_y, acc} == $past({idx_y, acc}) && psw[PSW_V] == $past(psw[PSW_V]))
		else $error("word compare altered operands");

	inc_word_c: cover property (done && op == OP_W_INC);
	swap_mem_c: cover property (done && op == OP_SWAP_MA);
	indirect_c: cover property (done && mode == AM_IDY && op == OP_STORE_A);
	illegal_c: cover property (illegal_op);
endmodule // lst_core

// ==== lst_pkg.sv ====
// Purpose: shared types and constants of the load/store/transfer engine
// Assumes: one core clock; memory read data is valid in the cycle of mem_rd
// Notes: program and data share one 16-bit byte address space
package lst_pkg;
	localparam int ADDR_W = 16;
	localparam logic [15:0] RESET_PC = 16'h0000;
	localparam logic [7:0] RESET_SP = 8'hFF;
	localparam logic [7:0] RESET_PSW = 8'h00;
	localparam int PSW_N = 7;
	localparam int PSW_V = 6;
	localparam int PSW_G = 5;
	localparam int PSW_H = 3;
	localparam int PSW_Z = 1;
	localparam int PSW_C = 0;
	localparam logic [1:0] NOP_BYTES = 2'h1;
	localparam logic [2:0] NOP_CYCLES = 3'h2;

	typedef enum logic [3:0] {
		AM_NONE, AM_IMM, AM_DP, AM_DPX, AM_DPY, AM_ABS, AM_ABSY,
		AM_IDX, AM_IDY, AM_XI, AM_XIP
	} lst_mode_t;

	typedef enum logic [4:0] {
		OP_NOP, OP_LOAD_A, OP_LOAD_X, OP_LOAD_Y, OP_STORE_A, OP_STORE_X,
		OP_STORE_Y, OP_STORE_IMM, OP_A_TO_X, OP_A_TO_Y, OP_SP_TO_X,
		OP_X_TO_A, OP_X_TO_SP, OP_Y_TO_A, OP_SWAP_AX, OP_SWAP_AY,
		OP_SWAP_XY, OP_SWAP_MA, OP_W_ADD, OP_W_SUB, OP_W_CMP, OP_W_INC,
		OP_W_DEC, OP_W_LOAD, OP_W_STORE
	} lst_op_t;

	typedef struct packed {
		lst_mode_t mode;
		lst_op_t op;
		logic [1:0] nbytes;
		logic [2:0] ncyc;
		logic known;
	} lst_dec_t;
endpackage

// ==== lst_decode.sv ====
// Purpose: opcode table giving mode, operation, byte and cycle counts
// Assumes: opcode is stable for the whole instruction
// Notes: unknown opcodes come back as a one-byte, two-cycle no-op
`timescale 1ns/1ps
module lst_decode (
	input wire logic [7:0] opcode,
	output lst_pkg::lst_mode_t mode,
	output lst_pkg::lst_op_t op,
	output logic [1:0] nbytes,
	output logic [2:0] ncyc,
	output logic known
);
	import lst_pkg::*;
	lst_dec_t d;

	always_comb begin
		d = '{AM_NONE, OP_NOP, NOP_BYTES, NOP_CYCLES, 1'b0};
		case (opcode)
			8'hC4: d = '{AM_IMM, OP_LOAD_A, 2'h2, 3'h2, 1'b1};
			8'hC5: d = '{AM_DP, OP_LOAD_A, 2'h2, 3'h3, 1'b1};
			8'hC6: d = '{AM_DPX, OP_LOAD_A, 2'h2, 3'h4, 1'b1};
			8'hC7: d = '{AM_ABS, OP_LOAD_A, 2'h3, 3'h4, 1'b1};
			8'hD5: d = '{AM_ABSY, OP_LOAD_A, 2'h3, 3'h5, 1'b1};
			8'hD6: d = '{AM_IDX, OP_LOAD_A, 2'h2, 3'h6, 1'b1};
			8'hD7: d = '{AM_IDY, OP_LOAD_A, 2'h2, 3'h6, 1'b1};
			8'hD4: d = '{AM_XI, OP_LOAD_A, 2'h1, 3'h3, 1'b1};
			8'hDB: d = '{AM_XIP, OP_LOAD_A, 2'h1, 3'h4, 1'b1};
			8'hE4: d = '{AM_DP, OP_STORE_IMM, 2'h3, 3'h5, 1'b1};
			8'h1E: d = '{AM_IMM, OP_LOAD_X, 2'h2, 3'h2, 1'b1};
			8'hCC: d = '{AM_DP, OP_LOAD_X, 2'h2, 3'h3, 1'b1};
			8'hCD: d = '{AM_DPY, OP_LOAD_X, 2'h2, 3'h4, 1'b1};
			8'hDC: d = '{AM_ABS, OP_LOAD_X, 2'h3, 3'h4, 1'b1};
			8'h3E: d = '{AM_IMM, OP_LOAD_Y, 2'h2, 3'h2, 1'b1};
			8'hC9: d = '{AM_DP, OP_LOAD_Y, 2'h2, 3'h3, 1'b1};
			8'hD9: d = '{AM_DPX, OP_LOAD_Y, 2'h2, 3'h4, 1'b1};
			8'hD8: d = '{AM_ABS, OP_LOAD_Y, 2'h3, 3'h4, 1'b1};
			8'hE5: d = '{AM_DP, OP_STORE_A, 2'h2, 3'h4, 1'b1};
			8'hE6: d = '{AM_DPX, OP_STORE_A, 2'h2, 3'h5, 1'b1};
			8'hE7: d = '{AM_ABS, OP_STORE_A, 2'h3, 3'h5, 1'b1};
			8'hF5: d = '{AM_ABSY, OP_STORE_A, 2'h3, 3'h6, 1'b1};
			8'hF6: d = '{AM_IDX, OP_STORE_A, 2'h2, 3'h7, 1'b1};
			8'hF7: d = '{AM_IDY, OP_STORE_A, 2'h2, 3'h7, 1'b1};
			8'hF4: d = '{AM_XI, OP_STORE_A, 2'h1, 3'h4, 1'b1};
			8'hFB: d = '{AM_XIP, OP_STORE_A, 2'h1, 3'h4, 1'b1};
			8'hEC: d = '{AM_DP, OP_STORE_X, 2'h2, 3'h4, 1'b1};
			8'hED: d = '{AM_DPY, OP_STORE_X, 2'h2, 3'h5, 1'b1};
			8'hFC: d = '{AM_ABS, OP_STORE_X, 2'h3, 3'h5, 1'b1};
			8'hE9: d = '{AM_DP, OP_STORE_Y, 2'h2, 3'h4, 1'b1};
			8'hF9: d = '{AM_DPX, OP_STORE_Y, 2'h2, 3'h5, 1'b1};
			8'hF8: d = '{AM_ABS, OP_STORE_Y, 2'h3, 3'h5, 1'b1};
			8'hE8: d = '{AM_NONE, OP_A_TO_X, 2'h1, 3'h2, 1'b1};
			8'h9F: d = '{AM_NONE, OP_A_TO_Y, 2'h1, 3'h2, 1'b1};
			8'hAE: d = '{AM_NONE, OP_SP_TO_X, 2'h1, 3'h2, 1'b1};
			8'hC8: d = '{AM_NONE, OP_X_TO_A, 2'h1, 3'h2, 1'b1};
			8'h8E: d = '{AM_NONE, OP_X_TO_SP, 2'h1, 3'h2, 1'b1};
			8'hBF: d = '{AM_NONE, OP_Y_TO_A, 2'h1, 3'h2, 1'b1};
			8'hEE: d = '{AM_NONE, OP_SWAP_AX, 2'h1, 3'h4, 1'b1};
			8'hDE: d = '{AM_NONE, OP_SWAP_AY, 2'h1, 3'h4, 1'b1};
			8'hBC: d = '{AM_DP, OP_SWAP_MA, 2'h2, 3'h5, 1'b1};
			8'hAD: d = '{AM_DPX, OP_SWAP_MA, 2'h2, 3'h6, 1'b1};
			8'hBB: d = '{AM_XI, OP_SWAP_MA, 2'h1, 3'h5, 1'b1};
			8'hFE: d = '{AM_NONE, OP_SWAP_XY, 2'h1, 3'h4, 1'b1};
			8'h1D: d = '{AM_DP, OP_W_ADD, 2'h2, 3'h5, 1'b1};
			8'h5D: d = '{AM_DP, OP_W_CMP, 2'h2, 3'h4, 1'b1};
			8'hBD: d = '{AM_DP, OP_W_DEC, 2'h2, 3'h6, 1'b1};
			8'h9D: d = '{AM_DP, OP_W_INC, 2'h2, 3'h6, 1'b1};
			8'h7D: d = '{AM_DP, OP_W_LOAD, 2'h2, 3'h5, 1'b1};
			8'hDD: d = '{AM_DP, OP_W_STORE, 2'h2, 3'h5, 1'b1};
			8'h3D: d = '{AM_DP, OP_W_SUB, 2'h2, 3'h5, 1'b1};
			default: d = '{AM_NONE, OP_NOP, NOP_BYTES, NOP_CYCLES, 1'b0};
		endcase
	end

	assign mode = d.mode;
	assign op = d.op;
	assign nbytes = d.nbytes;
	assign ncyc = d.ncyc;
	assign known = d.known;
endmodule // lst_decode

// ==== lst_word_alu.sv ====
// Purpose: 16-bit add, subtract, compare, increment and decrement
// Assumes: operands are held stable by the caller
// Notes: half-carry is taken at bit 11, the low nibble of the high byte
`timescale 1ns/1ps
module lst_word_alu (
	input wire lst_pkg::lst_op_t op,
	input wire logic [15:0] a_word,
	input wire logic [15:0] m_word,
	output logic [15:0] res,
	output logic flag_n,
	output logic flag_v,
	output logic flag_h,
	output logic flag_c,
	output logic flag_z
);
	import lst_pkg::*;
	logic [16:0] wide;
	logic [12:0] low;

	always_comb begin
		wide = {1'b0, m_word};
		low = 13'h0000;
		flag_v = 1'b0;
		flag_h = 1'b0;
		flag_c = 1'b0;
		case (op)
			OP_W_ADD: begin
				wide = {1'b0, a_word} + {1'b0, m_word};
				low = {1'b0, a_word[11:0]} + {1'b0, m_word[11:0]};
				flag_c = wide[16];
				flag_h = low[12];
				flag_v = (a_word[15] == m_word[15]) && (wide[15] != a_word[15]);
			end
			OP_W_SUB, OP_W_CMP: begin
				wide = {1'b0, a_word} - {1'b0, m_word};
				flag_c = !wide[16];
				flag_h = a_word[11:0] >= m_word[11:0];
				flag_v = (a_word[15] != m_word[15]) && (wide[15] != a_word[15]);
			end
			OP_W_INC: wide = {1'b0, m_word + 16'h0001};
			OP_W_DEC: wide = {1'b0, m_word - 16'h0001};
			default: wide = {1'b0, m_word};
		endcase
		res = wide[15:0];
		flag_n = wide[15];
		flag_z = wide[15:0] == 16'h0000;
	end
endmodule // lst_word_alu

// ==== lst_mem_model.sv ====
// Purpose: program and data memory seen by the core over its bus
// Assumes: zero wait states; reads answer in the cycle of mem_rd
// Notes: bench may poke the array between clock edges to lay down code
`timescale 1ns/1ps
module lst_mem_model (
	input wire logic clk_sys,
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_q;

	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		last_q = 8'h00;
	end

	// plain always, not always_ff: the bench also writes this array
	always @(posedge clk_sys) begin
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
		if (mem_rd) begin
			last_q <= mem[mem_addr];
		end
	end

	// undriven bus shows the inverse of the last byte, never a stale copy
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
endmodule // lst_mem_model

// ==== lst_core_tb.sv ====
// Purpose: self-checking bench for the load/store/transfer engine
// Assumes: direct page stays at 0x00xx since the G flag is never set
// Notes: each instruction is laid down at pc just before it is fetched
`timescale 1ns/1ps
module lst_core_tb;
	logic clk_sys, rst_n, mem_rd, mem_wr, instr_done, illegal_op;
	logic [7:0] mem_rdata, mem_wdata, acc, idx_x, idx_y, stack_ptr, psw;
	logic [15:0] mem_addr, pc;
	int errors, samples_checked;

	lst_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .instr_done(instr_done),
		.illegal_op(illegal_op), .acc(acc), .idx_x(idx_x), .idx_y(idx_y),
		.stack_ptr(stack_ptr), .psw(psw), .pc(pc));
	lst_mem_model mem_u (.clk_sys(clk_sys), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic regs(input logic [7:0] a, x, y, p);
		chk("acc", a, acc);
		chk("idx_x", x, idx_x);
		chk("idx_y", y, idx_y);
		chk("psw", p, psw);
	endtask

	task automatic memchk(input logic [15:0] ad, input logic [7:0] v);
		chk("memory", v, mem_u.mem[ad]);
	endtask

	// called at a falling edge inside cycle 0; returns once state landed
	task automatic step(input logic [23:0] code, input int nb, input int cy);
		int n;
		logic [15:0] pc_next;
		logic bad_op;
		pc_next = pc + 16'(nb);
		// only opcode 00 is left out of the table in this program
		bad_op = code[23:16] == 8'h00;
		for (int i = 0; i < nb; i++) mem_u.mem[pc + 16'(i)] = code[23-8*i -: 8];
		n = 1;
		while (instr_done !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			@(negedge clk_sys);
			n++;
		end
		chk("cycles", 8'(cy), 8'(n));
		chk("illegal_op", {7'h00, bad_op}, {7'h00, illegal_op});
		@(negedge clk_sys);
		chk("pc_lo", pc_next[7:0], pc[7:0]);
		chk("pc_hi", pc_next[15:8], pc[15:8]);
	endtask

	task automatic test_transfers;
		step(24'hC48000, 2, 2); regs(8'h80, 8'h00, 8'h00, 8'h80);
		step(24'hE80000, 1, 2); regs(8'h80, 8'h80, 8'h00, 8'h80);
		step(24'hC40000, 2, 2);
		step(24'h9F0000, 1, 2); regs(8'h00, 8'h80, 8'h00, 8'h02);
		step(24'hC80000, 1, 2); regs(8'h80, 8'h80, 8'h00, 8'h80);
		step(24'hAE0000, 1, 2); regs(8'h80, 8'hFF, 8'h00, 8'h80);
		step(24'h1E0000, 2, 2);
		step(24'h3E7F00, 2, 2);
		step(24'h8E0000, 1, 2); regs(8'h80, 8'h00, 8'h7F, 8'h02);
		chk("stack_ptr", 8'h00, stack_ptr);
		step(24'hBF0000, 1, 2); regs(8'h7F, 8'h00, 8'h7F, 8'h00);
		$display("test transfers done");
	endtask

	task automatic test_stores;
		step(24'hC45A00, 2, 2);
		step(24'h1EF000, 2, 2);
		step(24'h3E9C00, 2, 2);
		step(24'hE5E000, 2, 4); memchk(16'h00E0, 8'h5A);
		step(24'hECE100, 2, 4); memchk(16'h00E1, 8'hF0);
		step(24'hED4000, 2, 5); memchk(16'h00DC, 8'hF0);
		step(24'hFC0003, 3, 5); memchk(16'h0300, 8'hF0);
		step(24'hE9E200, 2, 4); memchk(16'h00E2, 8'h9C);
		step(24'hF80103, 3, 5); memchk(16'h0301, 8'h9C);
		step(24'hE4E377, 3, 5); memchk(16'h00E3, 8'h77);
		step(24'hF60600, 2, 7); memchk(16'h0400, 8'h5A);
		regs(8'h5A, 8'hF0, 8'h9C, 8'h80);
		step(24'hFB0000, 1, 4); memchk(16'h00F0, 8'h5A);
		regs(8'h5A, 8'hF1, 8'h9C, 8'h80);
		step(24'hDB0000, 1, 4); regs(8'h00, 8'hF2, 8'h9C, 8'h02);
		step(24'hF40000, 1, 4); memchk(16'h00F2, 8'h00);
		$display("test stores done");
	endtask

	task automatic test_swaps;
		step(24'hC41100, 2, 2);
		step(24'h1E8200, 2, 2);
		step(24'hEE0000, 1, 4); regs(8'h82, 8'h11, 8'h9C, 8'h80);
		step(24'hDE0000, 1, 4); regs(8'h9C, 8'h11, 8'h82, 8'h80);
		step(24'hFE0000, 1, 4); regs(8'h9C, 8'h82, 8'h11, 8'h80);
		step(24'hBCE000, 2, 5); regs(8'h5A, 8'h82, 8'h11, 8'h00);
		memchk(16'h00E0, 8'h9C);
		$display("test swaps done");
	endtask

	task automatic test_words;
		step(24'hE4E834, 3, 5);
		step(24'hE4E912, 3, 5);
		step(24'hE4EA00, 3, 5);
		step(24'hE4EBE0, 3, 5);
		step(24'h7DE800, 2, 5); regs(8'h34, 8'h82, 8'h12, 8'h00);
		step(24'h1DE800, 2, 5); regs(8'h68, 8'h82, 8'h24, 8'h00);
		step(24'h1DEA00, 2, 5); regs(8'h68, 8'h82, 8'h04, 8'h01);
		step(24'h3DEA00, 2, 5); regs(8'h68, 8'h82, 8'h24, 8'h08);
		step(24'h5DE800, 2, 4); regs(8'h68, 8'h82, 8'h24, 8'h09);
		step(24'h9DEA00, 2, 6); memchk(16'h00EA, 8'h01);
		chk("psw", 8'h89, psw);
		step(24'hBDEA00, 2, 6); memchk(16'h00EA, 8'h00);
		chk("psw", 8'h89, psw);
		step(24'hDDEC00, 2, 5); memchk(16'h00EC, 8'h68);
		memchk(16'h00ED, 8'h24);
		chk("psw", 8'h89, psw);
		$display("test words done");
	endtask

	// code stays below 0x0090, so every data address here is clear of it
	task automatic test_loads;
		step(24'h1EE800, 2, 2);
		step(24'h3E0200, 2, 2);
		step(24'hC5E300, 2, 3);
		regs(8'h77, 8'hE8, 8'h02, 8'h09);
		step(24'hC6F800, 2, 4);
		regs(8'h9C, 8'hE8, 8'h02, 8'h89);
		step(24'hC70004, 3, 4);
		regs(8'h5A, 8'hE8, 8'h02, 8'h09);
		step(24'hD5FE02, 3, 5);
		regs(8'hF0, 8'hE8, 8'h02, 8'h89);
		step(24'hD60E00, 2, 6);
		regs(8'h5A, 8'hE8, 8'h02, 8'h09);
		step(24'hD7F600, 2, 6);
		regs(8'h00, 8'hE8, 8'h02, 8'h0B);
		step(24'hD40000, 1, 3);
		regs(8'h34, 8'hE8, 8'h02, 8'h09);
		step(24'hCCE900, 2, 3);
		regs(8'h34, 8'h12, 8'h02, 8'h09);
		step(24'hCDEA00, 2, 4);
		regs(8'h34, 8'h68, 8'h02, 8'h09);
		step(24'hDC0103, 3, 4);
		regs(8'h34, 8'h9C, 8'h02, 8'h89);
		step(24'hC9E100, 2, 3);
		regs(8'h34, 8'h9C, 8'hF0, 8'h89);
		step(24'hD94C00, 2, 4);
		regs(8'h34, 8'h9C, 8'h34, 8'h09);
		step(24'hD80003, 3, 4);
		regs(8'h34, 8'h9C, 8'hF0, 8'h89);
		step(24'hE64400, 2, 5);
		memchk(16'h00E0, 8'h34);
		step(24'hE71003, 3, 5);
		memchk(16'h0310, 8'h34);
		step(24'hF50003, 3, 6);
		memchk(16'h03F0, 8'h34);
		step(24'hF7F600, 2, 7);
		memchk(16'h04F0, 8'h34);
		step(24'hF94D00, 2, 5);
		memchk(16'h00E9, 8'hF0);
		regs(8'h34, 8'h9C, 8'hF0, 8'h89);
		step(24'hC4A500, 2, 2);
		step(24'hAD4400, 2, 6);
		regs(8'h34, 8'h9C, 8'hF0, 8'h09);
		memchk(16'h00E0, 8'hA5);
		step(24'h1EEB00, 2, 2);
		step(24'hBB0000, 1, 5);
		regs(8'hE0, 8'hEB, 8'hF0, 8'h89);
		memchk(16'h00EB, 8'h34);
		step(24'h000000, 1, 2);
		regs(8'hE0, 8'hEB, 8'hF0, 8'h89);
		$display("test loads done");
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// generous span: the whole program needs well under 500 cycles
	initial begin
		#(2000 * 40);
		errors++;
		complete_run();
	end

	initial begin
		errors = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		repeat (16) @(negedge clk_sys);
		// pokes wait until the model has cleared its array at time zero
		mem_u.mem[16'h00F7] = 8'h04;
		mem_u.mem[16'h00F2] = 8'hFF;
		rst_n = 1'b1;
		test_transfers();
		test_stores();
		test_swaps();
		test_words();
		test_loads();
		complete_run();
	end
endmodule // lst_core_tb
